// file: bench/amt_address_map_table_tb.sv
// testbench: fills, refreshes and queries the address map table
// assumes the checker is bound and the requester model is in bench/
`timescale 1ns/1ps
module amt_address_map_table_tb;
    localparam         TICK = 1;
    localparam [31:0]  BASE = 32'h0A000000;
    localparam [47:0]  MB   = 48'h020000000000;
    reg         clk_sys = 1'b0;
    reg         rst_n   = 1'b0;
    reg [47:0]  my_mac  = 48'h02AABBCCDDEE;
    reg [31:0]  my_ip   = 32'hC0A80105;
    reg         arp_v   = 1'b0;
    reg         ip_v    = 1'b0;
    reg [31:0]  u_ip    = 32'h0;
    reg [47:0]  u_mac   = 48'h0;
    reg [3:0]   go      = 4'h0;
    reg [127:0] keys    = 128'h0;
    wire [3:0]  req;
    wire [127:0] req_ip;
    wire        tx_ready, rsp_valid, rsp_found, tx_valid, tx_sof, tx_eof;
    wire [3:0]  grant;
    wire [1:0]  rsp_id;
    wire [47:0] rsp_mac;
    wire [7:0]  tx_data;
    integer     n_fail = 0;
    integer     checks_done = 0;
    reg [7:0]   frame[$];
    integer     j;
    always #10 clk_sys = ~clk_sys;
    amt_req_model amt_req_model_inst (.i_clk_sys(clk_sys), .i_go(go), .i_keys(keys),
        .i_grant(grant), .o_req(req), .o_req_ip(req_ip), .o_tx_ready(tx_ready));
    amt_address_map_table #(.TICK_CYC(TICK)) amt_address_map_table_inst (
        .i_clk_sys(clk_sys), .i_rst_n(rst_n), .i_my_mac(my_mac), .i_my_ip(my_ip),
        .i_req(req), .i_req_ip(req_ip), .i_arp_rx_valid(arp_v), .i_arp_rx_ip(u_ip),
        .i_arp_rx_mac(u_mac), .i_ip_rx_valid(ip_v), .i_ip_rx_ip(u_ip), .i_ip_rx_mac(u_mac),
        .i_tx_ready(tx_ready), .o_grant(grant), .o_rsp_valid(rsp_valid), .o_rsp_id(rsp_id),
        .o_rsp_found(rsp_found), .o_rsp_mac(rsp_mac), .o_tx_data(tx_data),
        .o_tx_valid(tx_valid), .o_tx_sof(tx_sof), .o_tx_eof(tx_eof));
    always @(posedge clk_sys) begin
        if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
            frame.push_back(tx_data);
        end
    end
    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    task cmp(input string what, input logic [47:0] exp, input logic [47:0] got);
        begin
            checks_done = checks_done + 1;
            if (got !== exp) begin
                n_fail = n_fail + 1;
                $display("unexpected %s expected %h seen %h", what, exp, got);
            end
        end
    endtask
    task stop_test;
        begin
            $display("checks %0d failures %0d", checks_done, n_fail);
            if (n_fail == 0 && checks_done > 0) begin
                $display("TB: PASS");
            end else begin
                $display("TB: FAIL");
            end
            $finish;
        end
    endtask
    task upd(input bit src, input [31:0] ip, input [47:0] mac);
        begin
            @(negedge clk_sys);
            u_ip <= ip;
            u_mac <= mac;
            arp_v <= !src;
            ip_v <= src;
            @(negedge clk_sys);
            arp_v <= 1'b0;
            ip_v <= 1'b0;
            repeat (80) @(negedge clk_sys);
        end
    endtask
    task wait_rsp;
        integer k;
        begin
            k = 0;
            while (rsp_valid !== 1'b1 && k < 200) begin
                @(negedge clk_sys);
                k = k + 1;
            end
            cmp("rsp_valid", 48'h1, {47'h0, rsp_valid});
        end
    endtask
    task look(input [1:0] id, input [31:0] ip, input f, input [47:0] mac);
        begin
            @(negedge clk_sys);
            keys[32*id +: 32] <= ip;
            go <= 4'h1 << id;
            @(negedge clk_sys);
            go <= 4'h0;
            wait_rsp;
            cmp("rsp_id", {46'h0, id}, {46'h0, rsp_id});
            cmp("rsp_found", {47'h0, f}, {47'h0, rsp_found});
            cmp("rsp_mac", mac, rsp_mac);
        end
    endtask
    task chk_frame(input [31:0] tip);
        reg [335:0] e;
        integer     i;
        begin
            e = {48'hFFFFFFFFFFFF, my_mac, 16'h0806, 16'h0001, 16'h0800, 8'h06, 8'h04,
                 16'h0001, my_mac, my_ip, 48'h0, tip};
            i = 0;
            while (frame.size() < 42 && i < 400) begin
                @(negedge clk_sys);
                i = i + 1;
            end
            cmp("frame_len", 48'd42, frame.size());
            for (i = 0; i < 42 && i < frame.size(); i = i + 1) begin
                cmp("frame_byte", {40'h0, e[335-8*i -: 8]}, {40'h0, frame[i]});
            end
        end
    endtask
    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task t_fill_oldest;
        begin
            for (j = 0; j < 129; j = j + 1) begin
                upd(j[0], BASE + j, MB + j);
            end
            frame.delete();
            look(2'h0, BASE, 1'b0, 48'h0);
            look(2'h1, BASE + 1, 1'b1, MB + 1);
            look(2'h2, BASE + 128, 1'b1, MB + 128);
            chk_frame(BASE);
        end
    endtask
    task t_refresh;
        begin
            upd(1'b0, BASE + 1, 48'h0BAD00000001);
            look(2'h3, BASE + 1, 1'b1, 48'h0BAD00000001);
            upd(1'b1, BASE + 200, MB + 200);
            look(2'h0, BASE + 1, 1'b0, 48'h0);
            look(2'h1, BASE + 2, 1'b1, MB + 2);
            look(2'h2, BASE + 200, 1'b1, MB + 200);
        end
    endtask
    task t_arbiter;
        reg [3:0] seen;
        begin
            seen = 4'h0;
            @(negedge clk_sys);
            keys <= {BASE + 5, BASE + 4, BASE + 3, BASE + 2};
            go <= 4'hF;
            @(negedge clk_sys);
            go <= 4'h0;
            for (j = 0; j < 4; j = j + 1) begin
                @(negedge clk_sys);
                wait_rsp;
                seen = seen | (4'h1 << rsp_id);
                cmp("arb_mac", MB + 2 + rsp_id, rsp_mac);
            end
            cmp("served", 48'hF, {44'h0, seen});
        end
    endtask
    task t_stale;
        begin
            repeat (60100) @(negedge clk_sys);
            frame.delete();
            look(2'h1, BASE + 2, 1'b0, MB + 2);
            chk_frame(BASE + 2);
        end
    endtask
    initial begin
        repeat (12) @(negedge clk_sys);
        rst_n = 1'b1;
        cmp("idle_out", 48'h0, {42'h0, grant, rsp_valid, tx_valid});
        t_fill_oldest;
        t_refresh;
        t_arbiter;
        t_stale;
        stop_test;
    end
    initial begin
        repeat (90000) @(posedge clk_sys);
        n_fail = n_fail + 1;
        stop_test;
    end
endmodule // amt_address_map_table_tb

// file: bench/amt_req_model.sv
// model of four requesters and a stalling frame sink
// assumes the table samples on the rising edge; this model moves on the falling edge
`timescale 1ns/1ps
module amt_req_model (
    input  wire         i_clk_sys,
    input  wire [3:0]   i_go,
    input  wire [127:0] i_keys,
    input  wire [3:0]   i_grant,
    output reg  [3:0]   o_req,
    output reg  [127:0] o_req_ip,
    output reg          o_tx_ready
);
    // ----------------------------------------------------------------
    // request hold and frame sink
    // ----------------------------------------------------------------
    reg [1:0] ph_r;
    integer   n;
    initial begin
        o_req = 4'h0;
        o_req_ip = 128'h0;
        o_tx_ready = 1'b0;
        ph_r = 2'h0;
    end
    always @(negedge i_clk_sys) begin
        for (n = 0; n < 4; n = n + 1) begin
            if (i_grant[n]) begin
                o_req[n] <= 1'b0;
                o_req_ip[32*n +: 32] <= ~o_req_ip[32*n +: 32];
            end else if (i_go[n]) begin
                o_req[n] <= 1'b1;
                o_req_ip[32*n +: 32] <= i_keys[32*n +: 32];
            end
        end
        ph_r <= ph_r + 2'h1;
        o_tx_ready <= (ph_r == 2'h0);
    end
endmodule // amt_req_model

// file: bench/amt_table_chk.sv
// checker: lookup and arp frame timing of the address map table
// assumes binding to amt_address_map_table, single clock i_clk_sys
`timescale 1ns/1ps
module amt_table_chk #(
    parameter TICK_CYC = 4
) (
    input wire        i_clk_sys,
    input wire        i_rst_n,
    input wire [3:0]  i_req,
    input wire        i_tx_ready,
    input wire [3:0]  o_grant,
    input wire        o_rsp_valid,
    input wire [1:0]  o_rsp_id,
    input wire [7:0]  o_tx_data,
    input wire        o_tx_valid,
    input wire        o_tx_sof,
    input wire        o_tx_eof
);
    // ----------------------------------------------------------------
    // helper state
    // ----------------------------------------------------------------
    reg [1:0] gid_r;
    reg       busy_r;
    reg [5:0] bcnt_r;
    always @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            gid_r  <= 2'h0;
            busy_r <= 1'b0;
            bcnt_r <= 6'h00;
        end else begin
            if (|o_grant) begin
                gid_r <= {o_grant[3] | o_grant[2], o_grant[3] | o_grant[1]};
            end
            if (|o_grant) begin
                busy_r <= 1'b1;
            end else if (o_rsp_valid) begin
                busy_r <= 1'b0;
            end
            if (o_tx_valid && i_tx_ready) begin
                bcnt_r <= o_tx_eof ? 6'h00 : bcnt_r + 6'h01;
            end
        end
    end
    // ----------------------------------------------------------------
    // properties
    // ----------------------------------------------------------------
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_n);
    sequence s_taken;
        |o_grant;
    endsequence
    sequence s_answer;
        ##[5:66] o_rsp_valid;
    endsequence
    a_grant_one_hot: assert property ($onehot0(o_grant))
        else $error("more than one grant");
    a_grant_from_req: assert property (s_taken |-> (o_grant & ~$past(i_req)) == 4'h0)
        else $error("grant without request");
    a_one_at_time: assert property (s_taken |-> !busy_r)
        else $error("grant while a lookup runs");
    a_rsp_in_window: assert property (s_taken |-> s_answer)
        else $error("answer later than the window");
    a_rsp_not_early: assert property (s_taken |=> !o_rsp_valid [*4])
        else $error("answer earlier than the window");
    a_rsp_one_pulse: assert property (o_rsp_valid |-> busy_r ##1 !o_rsp_valid)
        else $error("answer not a single pulse of a granted lookup");
    a_rsp_id_match: assert property (o_rsp_valid |-> o_rsp_id == gid_r)
        else $error("answer id differs from grant");
    a_tx_byte_hold: assert property (o_tx_valid && !i_tx_ready |=>
        o_tx_valid && $stable(o_tx_data) && $stable(o_tx_sof) && $stable(o_tx_eof))
        else $error("frame byte changed while stalled");
    a_frame_sof_ff: assert property ($rose(o_tx_valid) |-> o_tx_sof && o_tx_data == 8'hFF)
        else $error("frame start not broadcast");
    a_frame_len: assert property (o_tx_valid && o_tx_eof |-> bcnt_r == 6'h29)
        else $error("frame end at wrong byte");
endmodule // amt_table_chk

bind amt_address_map_table amt_table_chk #(.TICK_CYC(TICK_CYC)) amt_table_chk_inst (
    .i_clk_sys  (i_clk_sys),
    .i_rst_n    (i_rst_n),
    .i_req      (i_req),
    .i_tx_ready (i_tx_ready),
    .o_grant    (o_grant),
    .o_rsp_valid(o_rsp_valid),
    .o_rsp_id   (o_rsp_id),
    .o_tx_data  (o_tx_data),
    .o_tx_valid (o_tx_valid),
    .o_tx_sof   (o_tx_sof),
    .o_tx_eof   (o_tx_eof)
);

// file: common/amt_map.vh
// constants for the address map table and its arp query sender
// assumes inclusion by every design file of the block
`ifndef AMT_MAP_VH
`define AMT_MAP_VH

// --------------------------------------------------------------------------
// table geometry
// --------------------------------------------------------------------------
`define AMT_DEPTH          128
`define AMT_SLOT_W         7
`define AMT_BANK_AW        6
`define AMT_BANK_LAST      6'h3F
`define AMT_MAC_W          48
`define AMT_IP_W           32
`define AMT_TS_W           20
`define AMT_REC_W          100
`define AMT_REC_IP_LSB     0
`define AMT_REC_MAC_LSB    32
`define AMT_REC_TS_LSB     80
`define AMT_NREQ           4

// --------------------------------------------------------------------------
// timing
// --------------------------------------------------------------------------
`define AMT_CLK_NS         20
`define AMT_RSP_MIN_NS     100
`define AMT_RSP_MAX_NS     1330
`define AMT_RSP_MIN_CYC    ((`AMT_RSP_MIN_NS + `AMT_CLK_NS - 1) / `AMT_CLK_NS)
`define AMT_RSP_MAX_CYC    (`AMT_RSP_MAX_NS / `AMT_CLK_NS)
`define AMT_TICK_NS        1000000
`define AMT_TICK_CYC       (`AMT_TICK_NS / `AMT_CLK_NS)
`define AMT_REFRESH_PERIOD 20'h0EA60

// --------------------------------------------------------------------------
// arp request frame
// --------------------------------------------------------------------------
`define AMT_ARP_LAST       6'h29
`define AMT_ETYPE_ARP      16'h0806
`define AMT_HTYPE_ETH      16'h0001
`define AMT_PTYPE_IP       16'h0800
`define AMT_HLEN           8'h06
`define AMT_PLEN           8'h04
`define AMT_OPER_REQ       16'h0001

`endif

// file: hdl/amt_address_map_table.v
// address map table: shared ipv4 to mac routing table with arbitrated lookups
// assumes all inputs come from logic on i_clk_sys; requesters hold until granted
//
// Summary of operation
// - the table holds exactly 128 records in two 64-deep ram banks.
// - each record holds a 48-bit mac, its 32-bit ipv4 address and a refresh timestamp.
// - arp replies and received ip packets continuously refresh or add records.
// - a round-robin pointer names the earliest-added record, which a new address overwrites even if it was refreshed since.
// - a lookup searches for the ipv4 key and returns the matching mac.
// - a missing or stale key makes the arp query sender broadcast a request for it.
// - a lookup answers between 100 ns and 1.33 us after its grant.
// - a round-robin arbiter lets one of four requesters be served at a time.
// - the arp query sender builds a broadcast who-has frame for the target address.
// - everything runs on the single clock i_clk_sys; its cycle counts assume a 20 ns period, so a slower clock stretches the lookup window and the tick.
// - the refresh period is a fixed 20-bit constant.
`timescale 1ns/1ps
`include "amt_map.vh"

module amt_address_map_table #(
    parameter TICK_CYC = `AMT_TICK_CYC
) (
    input  wire         i_clk_sys,
    input  wire         i_rst_n,
    input  wire [47:0]  i_my_mac,
    input  wire [31:0]  i_my_ip,
    input  wire [3:0]   i_req,
    input  wire [127:0] i_req_ip,
    input  wire         i_arp_rx_valid,
    input  wire [31:0]  i_arp_rx_ip,
    input  wire [47:0]  i_arp_rx_mac,
    input  wire         i_ip_rx_valid,
    input  wire [31:0]  i_ip_rx_ip,
    input  wire [47:0]  i_ip_rx_mac,
    input  wire         i_tx_ready,
    output reg  [3:0]   o_grant,
    output reg          o_rsp_valid,
    output reg  [1:0]   o_rsp_id,
    output reg          o_rsp_found,
    output reg  [47:0]  o_rsp_mac,
    output wire [7:0]   o_tx_data,
    output wire         o_tx_valid,
    output wire         o_tx_sof,
    output wire         o_tx_eof
);

    localparam ST_IDLE = 2'b00;
    localparam ST_SCAN = 2'b01;
    localparam ST_WAIT = 2'b10;
    localparam ST_DONE = 2'b11;
    localparam [6:0]  RSP_MIN = `AMT_RSP_MIN_CYC;
    localparam [5:0]  LAST_PAIR = `AMT_BANK_LAST;
    localparam [19:0] REFRESH = `AMT_REFRESH_PERIOD;

    // --------------------------------------------------------------------------
    // timestamp base
    // --------------------------------------------------------------------------
    reg  [31:0] div_r;
    reg  [19:0] now_r;

    always @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            div_r <= 32'h0000_0000;
            now_r <= 20'h00000;
        end else if (div_r == TICK_CYC - 1) begin
            div_r <= 32'h0000_0000;
            now_r <= now_r + 20'h00001;
        end else begin
            div_r <= div_r + 32'h0000_0001;
        end
    end

    // --------------------------------------------------------------------------
    // record storage
    // --------------------------------------------------------------------------
    reg  [1:0]   state_r;
    reg  [5:0]   idx_r;
    reg  [5:0]   cmp_idx_r;
    reg          cmp_en_r;
    reg          we_r;
    reg  [6:0]   wslot_r;
    reg  [99:0]  wrec_r;
    reg  [127:0] used_r;
    reg  [31:0]  key_r;
    wire [99:0]  rd_rec [0:1];
    wire [1:0]   match;

    genvar b;
    generate
        for (b = 0; b < 2; b = b + 1) begin : g_bank
            reg [99:0] mem [0:63];
            reg [99:0] rd_r;
            always @(posedge i_clk_sys) begin
                if (we_r && wslot_r[0] == b) begin
                    mem[wslot_r[6:1]] <= wrec_r;
                end
                rd_r <= mem[idx_r];
            end
            assign rd_rec[b] = rd_r;
            assign match[b]  = cmp_en_r & used_r[{cmp_idx_r, 1'b0} + b]
                               & (rd_r[31:0] == key_r);
        end
    endgenerate

    // --------------------------------------------------------------------------
    // pending refresh sources
    // --------------------------------------------------------------------------
    reg         arp_pend_r;
    reg  [79:0] arp_rec_r;
    reg         ipp_pend_r;
    reg  [79:0] ipp_rec_r;
    reg         q_pend_r;
    reg  [31:0] q_ip_r;
    reg  [47:0] umac_r;
    reg         mode_upd_r;
    reg  [1:0]  who_r;
    reg  [1:0]  rr_r;
    reg  [6:0]  cnt_r;
    reg  [6:0]  oldest_r;
    reg         hit_r;
    reg  [6:0]  hit_slot_r;
    reg  [99:0] hit_rec_r;
    wire        take_arp;
    wire        take_ipp;
    wire        take_req;
    wire        q_start;
    wire        q_busy;
    wire        stale;
    wire        scan_hit;
    wire        scan_end;
    wire [19:0] age;
    reg  [1:0]  pick;
    reg         pick_ok;
    integer     k;

    assign take_arp = (state_r == ST_IDLE) & arp_pend_r;
    assign take_ipp = (state_r == ST_IDLE) & ~arp_pend_r & ipp_pend_r;
    assign take_req = (state_r == ST_IDLE) & ~arp_pend_r & ~ipp_pend_r & pick_ok;
    assign q_start  = q_pend_r & ~q_busy;
    assign age      = now_r - hit_rec_r[99:80];
    assign stale    = (age > REFRESH);
    assign scan_hit = match[0] | match[1];
    assign scan_end = scan_hit | (cmp_en_r & (cmp_idx_r == LAST_PAIR));

    // --------------------------------------------------------------------------
    // round-robin pick starting after the last served requester
    // --------------------------------------------------------------------------
    always @* begin
        pick    = 2'b00;
        pick_ok = 1'b0;
        for (k = 3; k >= 0; k = k - 1) begin
            if (i_req[rr_r + 2'b01 + k[1:0]]) begin
                pick    = rr_r + 2'b01 + k[1:0];
                pick_ok = 1'b1;
            end
        end
    end

    always @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            arp_pend_r <= 1'b0;
            arp_rec_r  <= 80'h0;
            ipp_pend_r <= 1'b0;
            ipp_rec_r  <= 80'h0;
            q_pend_r   <= 1'b0;
            q_ip_r     <= 32'h0000_0000;
        end else begin
            if (i_arp_rx_valid) begin
                arp_pend_r <= 1'b1;
                arp_rec_r  <= {i_arp_rx_mac, i_arp_rx_ip};
            end else if (take_arp) begin
                arp_pend_r <= 1'b0;
            end
            if (i_ip_rx_valid) begin
                ipp_pend_r <= 1'b1;
                ipp_rec_r  <= {i_ip_rx_mac, i_ip_rx_ip};
            end else if (take_ipp) begin
                ipp_pend_r <= 1'b0;
            end
            if (state_r == ST_DONE && !mode_upd_r && (!hit_r || stale)) begin
                q_pend_r <= 1'b1;
                q_ip_r   <= key_r;
            end else if (q_start) begin
                q_pend_r <= 1'b0;
            end
        end
    end

    // --------------------------------------------------------------------------
    // search and update sequencer
    // --------------------------------------------------------------------------
    always @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_r     <= ST_IDLE;
            idx_r       <= 6'h00;
            cmp_idx_r   <= 6'h00;
            cmp_en_r    <= 1'b0;
            we_r        <= 1'b0;
            wslot_r     <= 7'h00;
            wrec_r      <= 100'h0;
            used_r      <= 128'h0;
            key_r       <= 32'h0000_0000;
            umac_r      <= 48'h0000_0000_0000;
            mode_upd_r  <= 1'b0;
            who_r       <= 2'b00;
            rr_r        <= 2'b11;
            cnt_r       <= 7'h00;
            oldest_r    <= 7'h00;
            hit_r       <= 1'b0;
            hit_slot_r  <= 7'h00;
            hit_rec_r   <= 100'h0;
            o_grant     <= 4'h0;
            o_rsp_valid <= 1'b0;
            o_rsp_id    <= 2'b00;
            o_rsp_found <= 1'b0;
            o_rsp_mac   <= 48'h0000_0000_0000;
        end else begin
            o_grant     <= 4'h0;
            o_rsp_valid <= 1'b0;
            we_r        <= 1'b0;
            cnt_r       <= cnt_r + 7'h01;
            case (state_r)
                ST_IDLE: begin
                    idx_r    <= 6'h00;
                    cmp_en_r <= 1'b0;
                    hit_r    <= 1'b0;
                    cnt_r    <= 7'h01;
                    if (take_arp || take_ipp) begin
                        mode_upd_r <= 1'b1;
                        key_r      <= take_arp ? arp_rec_r[31:0] : ipp_rec_r[31:0];
                        umac_r     <= take_arp ? arp_rec_r[79:32] : ipp_rec_r[79:32];
                        state_r    <= ST_SCAN;
                    end else if (take_req) begin
                        mode_upd_r     <= 1'b0;
                        key_r          <= i_req_ip[pick * 32 +: 32];
                        who_r          <= pick;
                        rr_r           <= pick;
                        o_grant[pick]  <= 1'b1;
                        state_r        <= ST_SCAN;
                    end
                end
                ST_SCAN: begin
                    idx_r     <= idx_r + 6'h01;
                    cmp_idx_r <= idx_r;
                    cmp_en_r  <= ~scan_end;
                    if (scan_hit) begin
                        hit_r      <= 1'b1;
                        hit_slot_r <= {cmp_idx_r, ~match[0]};
                        hit_rec_r  <= match[0] ? rd_rec[0] : rd_rec[1];
                    end
                    // a late end skips the wait so a full miss stays inside the window
                    if (scan_end && (mode_upd_r || cnt_r >= RSP_MIN - 7'h01)) begin
                        state_r <= ST_DONE;
                    end else if (scan_end) begin
                        state_r <= ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    if (mode_upd_r || cnt_r >= RSP_MIN - 7'h01) begin
                        state_r <= ST_DONE;
                    end
                end
                ST_DONE: begin
                    state_r <= ST_IDLE;
                    if (mode_upd_r) begin
                        we_r    <= 1'b1;
                        wslot_r <= hit_r ? hit_slot_r : oldest_r;
                        wrec_r  <= {now_r, umac_r, key_r};
                        used_r[hit_r ? hit_slot_r : oldest_r] <= 1'b1;
                        if (!hit_r) begin
                            oldest_r <= oldest_r + 7'h01;
                        end
                    end else begin
                        o_rsp_valid <= 1'b1;
                        o_rsp_id    <= who_r;
                        o_rsp_found <= hit_r & ~stale;
                        o_rsp_mac   <= hit_r ? hit_rec_r[79:32] : 48'h0000_0000_0000;
                    end
                end
                default: state_r <= ST_IDLE;
            endcase
        end
    end

    // --------------------------------------------------------------------------
    // arp query sender
    // --------------------------------------------------------------------------
    amt_arp_query_sender u_query (
        .i_clk_sys   (i_clk_sys),
        .i_rst_n     (i_rst_n),
        .i_start     (q_start),
        .i_target_ip (q_ip_r),
        .i_my_mac    (i_my_mac),
        .i_my_ip     (i_my_ip),
        .i_tx_ready  (i_tx_ready),
        .o_busy      (q_busy),
        .o_tx_data   (o_tx_data),
        .o_tx_valid  (o_tx_valid),
        .o_tx_sof    (o_tx_sof),
        .o_tx_eof    (o_tx_eof)
    );

endmodule // amt_address_map_table

// file: hdl/amt_arp_query_sender.v
// arp query sender: assembles a broadcast who-has frame, one byte per accepted beat
// assumes a downstream sink with a ready handshake on the same clock
`timescale 1ns/1ps
`include "amt_map.vh"

module amt_arp_query_sender (
    input  wire        i_clk_sys,
    input  wire        i_rst_n,
    input  wire        i_start,
    input  wire [31:0] i_target_ip,
    input  wire [47:0] i_my_mac,
    input  wire [31:0] i_my_ip,
    input  wire        i_tx_ready,
    output reg         o_busy,
    output reg  [7:0]  o_tx_data,
    output reg         o_tx_valid,
    output reg         o_tx_sof,
    output reg         o_tx_eof
);

    reg  [5:0]  pos_r;
    reg  [31:0] tip_r;
    reg  [7:0]  byte_nxt;
    wire [5:0]  pos_nxt;
    wire        adv;
    localparam [15:0] ETYPE = `AMT_ETYPE_ARP;
    localparam [15:0] HTYPE = `AMT_HTYPE_ETH;
    localparam [15:0] PTYPE = `AMT_PTYPE_IP;
    localparam [15:0] OPER  = `AMT_OPER_REQ;

    assign adv     = o_tx_valid & i_tx_ready;
    assign pos_nxt = (o_busy & ~o_tx_valid) ? pos_r : pos_r + 6'h01;

    // --------------------------------------------------------------------------
    // frame byte selection
    // --------------------------------------------------------------------------
    always @* begin
        case (pos_nxt)
            6'h00, 6'h01, 6'h02, 6'h03, 6'h04, 6'h05: byte_nxt = 8'hFF;
            6'h06: byte_nxt = i_my_mac[47:40];
            6'h07: byte_nxt = i_my_mac[39:32];
            6'h08: byte_nxt = i_my_mac[31:24];
            6'h09: byte_nxt = i_my_mac[23:16];
            6'h0A: byte_nxt = i_my_mac[15:8];
            6'h0B: byte_nxt = i_my_mac[7:0];
            6'h0C: byte_nxt = ETYPE[15:8];
            6'h0D: byte_nxt = ETYPE[7:0];
            6'h0E: byte_nxt = HTYPE[15:8];
            6'h0F: byte_nxt = HTYPE[7:0];
            6'h10: byte_nxt = PTYPE[15:8];
            6'h11: byte_nxt = PTYPE[7:0];
            6'h12: byte_nxt = `AMT_HLEN;
            6'h13: byte_nxt = `AMT_PLEN;
            6'h14: byte_nxt = OPER[15:8];
            6'h15: byte_nxt = OPER[7:0];
            6'h16: byte_nxt = i_my_mac[47:40];
            6'h17: byte_nxt = i_my_mac[39:32];
            6'h18: byte_nxt = i_my_mac[31:24];
            6'h19: byte_nxt = i_my_mac[23:16];
            6'h1A: byte_nxt = i_my_mac[15:8];
            6'h1B: byte_nxt = i_my_mac[7:0];
            6'h1C: byte_nxt = i_my_ip[31:24];
            6'h1D: byte_nxt = i_my_ip[23:16];
            6'h1E: byte_nxt = i_my_ip[15:8];
            6'h1F: byte_nxt = i_my_ip[7:0];
            6'h26: byte_nxt = tip_r[31:24];
            6'h27: byte_nxt = tip_r[23:16];
            6'h28: byte_nxt = tip_r[15:8];
            6'h29: byte_nxt = tip_r[7:0];
            default: byte_nxt = 8'h00;
        endcase
    end

    // --------------------------------------------------------------------------
    // byte sequencer
    // --------------------------------------------------------------------------
    always @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pos_r      <= 6'h00;
            tip_r      <= 32'h0000_0000;
            o_busy     <= 1'b0;
            o_tx_data  <= 8'h00;
            o_tx_valid <= 1'b0;
            o_tx_sof   <= 1'b0;
            o_tx_eof   <= 1'b0;
        end else if (!o_busy) begin
            if (i_start) begin
                tip_r  <= i_target_ip;
                o_busy <= 1'b1;
                pos_r  <= 6'h00;
            end
        end else if (!o_tx_valid) begin
            o_tx_valid <= 1'b1;
            o_tx_sof   <= 1'b1;
            o_tx_data  <= 8'hFF;
        end else if (adv) begin
            if (pos_r == `AMT_ARP_LAST) begin
                o_busy     <= 1'b0;
                o_tx_valid <= 1'b0;
                o_tx_eof   <= 1'b0;
                o_tx_data  <= 8'h00;
            end else begin
                pos_r     <= pos_nxt;
                o_tx_data <= byte_nxt;
                o_tx_sof  <= 1'b0;
                o_tx_eof  <= (pos_nxt == `AMT_ARP_LAST);
            end
        end
    end

endmodule // amt_arp_query_sender
